// *** design/ebpc_top.sv ***
// How it works
// - The top four address lines carry address bits only on program-space accesses.
// - The low sixteen address lines carry the address for every space.
// - Address lines float during hold or when the offline input is low.
// - One shared 16-bit two-way data bus serves all external spaces.
// - Data drivers are off unless writing, and during reset or hold request.
// - Data drivers are off while the offline input is low.
// - Enabled holders keep each undriven data pin at its last level.
// - Holders are off after reset and software switches them by a control bit.
`timescale 1ns/1ps
`default_nettype none
`include "ebpc_regs.svh"
module ebpc_top
	import ebpc_pkg::*;
#(
	parameter int AW = `EBPC_ADDR_W,
	parameter int DW = `EBPC_DATA_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic system_reset_n,
	// bus state
	input wire logic hold_req,
	input wire logic hold_mode,
	input wire logic offline_n,
	// core side
	input wire ebpc_req_t req,
	output logic [DW-1:0] rdata,
	// holder control from bank_switch_control
	input wire logic bus_holder_enable_bit,
	input wire logic holder_wr,
	// address pins
	output logic [AW-1:0] addr_o,
	output logic addr_oe,
	// data pins
	input wire logic [DW-1:0] data_i,
	output logic [DW-1:0] data_o,
	output logic [DW-1:0] data_oe
);
	////////////////////////////////////////////////////////////////
	logic holder_en;
	logic [AW-1:0] addr_q;
	logic [DW-1:0] wdata_q;
	logic drive_q;
	logic [DW-1:0] keep_o;
	logic [DW-1:0] keep_oe;
	wire in_reset = srst || !system_reset_n;
	wire bus_off = hold_mode || !offline_n;
	wire data_block = in_reset || hold_req || !offline_n;
	wire is_prog = req.space == EBPC_SPACE_PROG;
	// named decodes of the request and of the pin state
	wire is_read = req.valid && !req.write;
	wire is_write = req.valid && req.write;
	wire write_blocked = is_write && data_block;
	wire [AW-`EBPC_LOW_ADDR_W-1:0] upper_addr = addr_q[AW-1:`EBPC_LOW_ADDR_W];
	wire [`EBPC_LOW_ADDR_W-1:0] low_addr = addr_q[`EBPC_LOW_ADDR_W-1:0];
	wire holder_live = holder_en && !in_reset;
	wire [DW-1:0] all_ones = {DW{1'b1}};
	wire [AW-1:0] next_addr = {is_prog ? req.addr[AW-1:`EBPC_LOW_ADDR_W] :
		{(AW-`EBPC_LOW_ADDR_W){1'b0}}, req.addr[`EBPC_LOW_ADDR_W-1:0]};
	wire next_drive = req.valid && req.write && !data_block;
	wire core_drive = drive_q && !data_block;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (in_reset) begin
			holder_en <= `EBPC_HOLDER_RST;
		end else if (holder_wr) begin
			holder_en <= bus_holder_enable_bit;
		end
	end
	// one-cycle write drive
	always_ff @(posedge clk) begin
		if (srst) begin
			drive_q <= 1'b0;
		end else begin
			drive_q <= next_drive;
		end
	end
	// address and write word stand until the next access
	always_ff @(posedge clk) begin
		if (srst) begin
			addr_q <= '0;
			wdata_q <= '0;
		end else if (req.valid) begin
			addr_q <= next_addr;
			wdata_q <= req.wdata;
		end
	end
	// read capture
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= '0;
		end else if (is_read) begin
			rdata <= data_i;
		end
	end
	////////////////////////////////////////////////////////////////
	ebpc_keeper #(.W(DW)) u_keeper (
		.clk(clk),
		.srst(srst),
		.keep_en(holder_live),
		.core_drive(core_drive),
		.pin_in(data_i),
		.keep_o(keep_o),
		.keep_oe(keep_oe)
	);
	assign addr_o = addr_q;
	assign addr_oe = !bus_off;
	assign data_o = core_drive ? wdata_q : keep_o;
	assign data_oe = core_drive ? {DW{1'b1}} : keep_oe;
	////////////////////////////////////////////////////////////////
	addr_float_a: assert property (@(posedge clk) disable iff (srst)
		bus_off |-> !addr_oe) else $error("address driven in hold or offline");
	data_off_a: assert property (@(posedge clk) disable iff (srst)
		(in_reset || (hold_req && !holder_en)) |-> data_oe == '0)
		else $error("data driven while blocked");
	offline_data_a: assert property (@(posedge clk) disable iff (srst)
		!offline_n |-> !core_drive) else $error("core drives data while offline");
	upper_addr_a: assert property (@(posedge clk) disable iff (srst)
		(req.valid && !is_prog) |=> addr_q[AW-1:`EBPC_LOW_ADDR_W] == '0)
		else $error("upper address set outside program space");
	low_addr_a: assert property (@(posedge clk) disable iff (srst)
		req.valid |=> addr_q[`EBPC_LOW_ADDR_W-1:0] == $past(req.addr[`EBPC_LOW_ADDR_W-1:0]))
		else $error("low address lost");
	write_drive_a: assert property (@(posedge clk) disable iff (srst)
		(req.valid && req.write && !data_block) ##1 !data_block |->
		data_o == $past(req.wdata) && data_oe == {DW{1'b1}})
		else $error("write data not driven");
	holder_keep_a: assert property (@(posedge clk) disable iff (srst)
		(holder_en && !in_reset && !core_drive) |-> data_oe == {DW{1'b1}})
		else $error("holder not keeping");
	holder_reset_a: assert property (@(posedge clk)
		$past(in_reset) |-> !holder_en) else $error("holder on after reset");
	holder_off_a: assert property (@(posedge clk) disable iff (srst)
		(!holder_en && !core_drive) |-> data_oe == '0)
		else $error("pins driven with holders off");
	////////////////////////////////////////////////////////////////
	// address bus
	prog_upper_a: assert property (@(posedge clk) disable iff (srst)
		(req.valid && is_prog) |=> upper_addr == $past(req.addr[AW-1:`EBPC_LOW_ADDR_W]))
		else $error("program upper address lost");
	low_take_a: assert property (@(posedge clk) disable iff (srst)
		req.valid |=> low_addr == $past(req.addr[`EBPC_LOW_ADDR_W-1:0]))
		else $error("low address not taken");
	addr_stand_a: assert property (@(posedge clk) disable iff (srst)
		!req.valid |=> $stable(addr_o))
		else $error("address moved without access");
	addr_on_a: assert property (@(posedge clk) disable iff (srst)
		!bus_off |-> addr_oe)
		else $error("address floats while bus free");
	hold_float_a: assert property (@(posedge clk) disable iff (srst)
		hold_mode |-> !addr_oe)
		else $error("address driven in hold mode");
	offline_addr_a: assert property (@(posedge clk) disable iff (srst)
		!offline_n |-> !addr_oe)
		else $error("address driven while offline");
	// data transfers
	read_capture_a: assert property (@(posedge clk) disable iff (srst)
		is_read |=> rdata == $past(data_i))
		else $error("read word not captured");
	rdata_stand_a: assert property (@(posedge clk) disable iff (srst)
		!is_read |=> $stable(rdata))
		else $error("read word moved without read");
	wdata_take_a: assert property (@(posedge clk) disable iff (srst)
		req.valid |=> wdata_q == $past(req.wdata))
		else $error("write word not taken");
	drive_value_a: assert property (@(posedge clk) disable iff (srst)
		core_drive |-> data_o == wdata_q && data_oe == all_ones)
		else $error("write word not on pins");
	// driver blocking
	write_take_a: assert property (@(posedge clk) disable iff (srst)
		(is_write && !data_block) |=> drive_q)
		else $error("free write not driven");
	read_quiet_a: assert property (@(posedge clk) disable iff (srst)
		is_read |=> !core_drive)
		else $error("data driven after read");
	idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
		!req.valid |=> !core_drive)
		else $error("data driven without write");
	blocked_write_a: assert property (@(posedge clk) disable iff (srst)
		write_blocked |=> !drive_q)
		else $error("blocked write driven");
	hold_quiet_a: assert property (@(posedge clk) disable iff (srst)
		hold_req |-> !core_drive)
		else $error("data driven during hold request");
	reset_quiet_a: assert property (@(posedge clk) disable iff (srst)
		in_reset |-> data_oe == '0)
		else $error("data driven during reset");
	offline_oe_a: assert property (@(posedge clk) disable iff (srst)
		(!offline_n && !holder_en) |-> data_oe == '0)
		else $error("data pins driven while offline");
	// holders
	keep_level_a: assert property (@(posedge clk) disable iff (srst)
		(holder_live && !core_drive) |-> data_o == $past(data_i))
		else $error("holder lost last level");
	keep_drive_a: assert property (@(posedge clk) disable iff (srst)
		(holder_live && !core_drive) |-> keep_oe == all_ones)
		else $error("holder idle while enabled");
	holder_write_a: assert property (@(posedge clk) disable iff (srst)
		(holder_wr && !in_reset) |=> holder_en == $past(bus_holder_enable_bit))
		else $error("holder bit write lost");
	holder_stay_a: assert property (@(posedge clk) disable iff (srst)
		(!holder_wr && !in_reset) |=> $stable(holder_en))
		else $error("holder bit moved without write");
	reset_keep_a: assert property (@(posedge clk) disable iff (srst)
		in_reset |-> keep_oe == '0)
		else $error("holder active during reset");
	free_pin_a: assert property (@(posedge clk) disable iff (srst)
		(!holder_en && !core_drive) |-> keep_oe == '0)
		else $error("keeper drives with holders off");
	free_out_a: assert property (@(posedge clk) disable iff (srst)
		(!holder_live && !core_drive) |-> data_oe == '0)
		else $error("undriven pins not released");
endmodule : ebpc_top
`default_nettype wire

// *** design/ebpc_regs.svh ***
`ifndef EBPC_REGS_SVH
`define EBPC_REGS_SVH
// address bus split
`define EBPC_ADDR_W 20
`define EBPC_LOW_ADDR_W 16
`define EBPC_DATA_W 16
// holder enable reset value
`define EBPC_HOLDER_RST 1'b0
`endif

// *** design/ebpc_pkg.sv ***
`include "ebpc_regs.svh"
package ebpc_pkg;
	typedef enum logic [1:0] {
		EBPC_SPACE_PROG = 2'b00,
		EBPC_SPACE_DATA = 2'b01,
		EBPC_SPACE_IO = 2'b10
	} ebpc_space_t;
	typedef struct packed {
		logic valid;
		logic write;
		ebpc_space_t space;
		logic [`EBPC_ADDR_W-1:0] addr;
		logic [`EBPC_DATA_W-1:0] wdata;
	} ebpc_req_t;
	typedef struct packed {
		logic [`EBPC_DATA_W-1:0] o;
		logic [`EBPC_DATA_W-1:0] oe;
	} ebpc_pins_t;
endpackage : ebpc_pkg

// *** design/ebpc_keeper.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebpc_regs.svh"
module ebpc_keeper #(
	parameter int W = `EBPC_DATA_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic keep_en,
	input wire logic core_drive,
	// pin level
	input wire logic [W-1:0] pin_in,
	// keeper drive
	output logic [W-1:0] keep_o,
	output logic [W-1:0] keep_oe
);
	logic [W-1:0] last;
	always_ff @(posedge clk) begin
		if (srst) begin
			last <= '0;
		end else begin
			last <= pin_in;
		end
	end
	// keep last level only when enabled and core idle
	assign keep_o = last;
	assign keep_oe = (keep_en && !core_drive) ? {W{1'b1}} : '0;
endmodule : ebpc_keeper
`default_nettype wire

// *** bench/ebpc_ext_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebpc_ext_mem (
	// bench control
	input wire logic drive,
	input wire logic [15:0] word,
	// data pins
	output logic [15:0] ext_d,
	output logic ext_oe
);
	// answers reads on the shared data bus
	assign ext_oe = drive;
	assign ext_d = word;
endmodule : ebpc_ext_mem
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ebpc_pkg::*;
	logic clk, srst, rst_n, hreq, hmode, off_n, hb, hwr, drv, on, aoe, eoe;
	ebpc_req_t req;
	logic [15:0] rdata, dout, doe, din, xd, ed, last;
	logic [19:0] ao;
	int n_mismatch, samples_checked;
	ebpc_top i_ebpc_top (.clk(clk), .srst(srst), .system_reset_n(rst_n), .hold_req(hreq),
		.hold_mode(hmode), .offline_n(off_n), .req(req), .rdata(rdata),
		.bus_holder_enable_bit(hb), .holder_wr(hwr), .addr_o(ao), .addr_oe(aoe),
		.data_i(din), .data_o(dout), .data_oe(doe));
	ebpc_ext_mem i_ebpc_ext_mem (.drive(drv), .word(xd), .ext_d(ed), .ext_oe(eoe));
	// weak keeper loses to the far side; a floating pin flips
	assign din = eoe ? ed : (doe & dout) | (~doe & ~last);
	always @(posedge clk) last <= din;
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic [19:0] g, input logic [19:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	// b: 0 free, 1 hold request, 2 hold mode, 3 offline
	task op(input logic w, input logic [1:0] s, input logic [1:0] b);
		logic [19:0] a;
		logic [15:0] d;
		logic go;
		a = 20'($urandom);
		d = 16'($urandom);
		go = w && !b[0];
		@(posedge clk);
		req <= '{1'b1, w, ebpc_space_t'(s), a, d};
		hreq <= b == 2'h1;
		hmode <= b == 2'h2;
		off_n <= b != 2'h3;
		drv <= !w;
		xd <= d;
		@(posedge clk);
		req.valid <= 1'b0;
		drv <= 1'b0;
		#1;
		chk(ao, s == 2'h0 ? a : {4'h0, a[15:0]});
		chk(20'(aoe), 20'(!b[1]));
		if (go || !on || b == 2'h3) chk(20'(doe), (go || on) ? 20'hffff : 20'h0);
		if (go) chk(20'(dout), 20'(d));
		if (!w) chk(20'(rdata), 20'(d));
		@(posedge clk);
		#1;
		if (!b[0]) chk(20'(doe), on ? 20'hffff : 20'h0);
		if (!b[0] && on) chk(20'(dout), 20'(d));
	endtask : op
	task set_hb(input logic v);
		@(posedge clk);
		hb <= v;
		hwr <= 1'b1;
		on = v;
		@(posedge clk);
		hwr <= 1'b0;
	endtask : set_hb
	task burst;
		for (int i = 0; i < 30; i++) op(1'($urandom), 2'($urandom_range(2)), 2'($urandom));
	endtask : burst
	////////////////////////////////////////////////////////////////
	initial begin
		{srst, rst_n, off_n, hreq, hmode, hb, hwr, drv, on} = 9'h1c0;
		req = '0;
		xd = '0;
		last = '0;
		void'($urandom(78029));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		burst();
		$display("holder off test done");
		set_hb(1'b1);
		burst();
		$display("holder on test done");
		@(posedge clk);
		rst_n <= 1'b0;
		on = 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		op(1'b1, 2'h0, 2'h0);
		$display("device reset test done");
		wrap_up();
	end
	initial begin
		#5000;
		n_mismatch++;
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
